// File: hdl/cfp_ctrl.sv
// controller end: avalon registers, command fifo, serial frame writer
//
// The implementer's own choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module cfp_ctrl (
  input  wire logic        mclk_in,
  input  wire logic        arst_n_in,
  input  wire logic [3:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  input  wire logic        line_start_in,
  input  wire logic        ref_strobe_in,
  input  wire logic        pix_strobe_in,
  input  wire logic        latch_clock_in,
  cfp_link_if.ctrl         link,
  output logic [9:0]       sample_word_out
);
  import cfp_pkg::*;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001, ST_LOW = 4'b0010, ST_HIGH = 4'b0100, ST_STROBE = 4'b1000
  } cfp_state_t;
  cfp_state_t st_r;
  logic [10:0] f_data;
  logic        f_valid;
  logic        f_ready;
  logic        f_pop;
  logic        push;
  logic        push_ok;
  logic [2:0]  pins_r;
  logic [2:0]  latch_sync_r;
  logic        busy_r;
  // one cycle wait gives a registered answer; a REG_CMD write stalls while fifo full
  assign push = avs_write_in && avs_waitrequest_out == 1'b0 && avs_address_in == REG_CMD;
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out <= '0;
    end else if ((avs_read_in || avs_write_in) && avs_waitrequest_out) begin
      avs_waitrequest_out <= (avs_write_in && avs_address_in == REG_CMD && !push_ok);
      if (avs_address_in == REG_STATUS) begin
        avs_readdata_out <= {30'h0, !push_ok, busy_r};
      end else if (avs_address_in == REG_PINS) begin
        avs_readdata_out <= {29'h0, pins_r};
      end else begin
        avs_readdata_out <= '0;
      end
    end else begin
      avs_waitrequest_out <= 1'b1;
    end
  end
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pins_r <= 3'h2;
    end else if (avs_write_in && !avs_waitrequest_out && avs_address_in == REG_PINS) begin
      pins_r <= avs_writedata_in[2:0];
    end
  end
  cfp_fifo #(.WIDTH(11), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk_in       (mclk_in),
    .arst_n_in     (arst_n_in),
    .in_data_in    (avs_writedata_in[10:0]),
    .in_valid_in   (push),
    .in_ready_out  (push_ok),
    .out_data_out  (f_data),
    .out_valid_out (f_valid),
    .out_ready_in  (f_ready)
  );
  // frame writer: start bit, select, ten level bits msb first, then strobe
  logic [11:0] frm_r;
  logic [3:0]  bit_r;
  logic [3:0]  cnt_r;
  assign f_ready = (st_r == ST_IDLE);
  assign f_pop   = f_ready && f_valid;
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_r <= ST_IDLE;
      frm_r <= '0;
      bit_r <= '0;
      cnt_r <= '0;
      busy_r <= 1'b0;
      link.serial_clock <= 1'b0;
      link.serial_data_in <= 1'b0;
      link.write_strobe <= 1'b0;
    end else begin
      case (st_r)
        ST_IDLE: begin
          busy_r <= f_pop;
          if (f_pop) begin
            frm_r <= {1'b0, f_data};
            link.serial_data_in <= 1'b0;
            bit_r <= 4'h0;
            cnt_r <= 4'h0;
            st_r <= ST_LOW;
          end
        end
        ST_LOW: begin
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == 4'(SCLK_HALF_CYC - 1)) begin
            cnt_r <= 4'h0;
            link.serial_clock <= 1'b1;
            st_r <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == 4'(SCLK_HALF_CYC - 1)) begin
            cnt_r <= 4'h0;
            link.serial_clock <= 1'b0;
            if (bit_r == 4'(FRAME_BITS - 1)) begin
              st_r <= ST_STROBE;
            end else begin
              link.serial_data_in <= frm_r[4'(FRAME_BITS - 2) - bit_r];
              bit_r <= bit_r + 4'h1;
              st_r <= ST_LOW;
            end
          end
        end
        ST_STROBE: begin
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == 4'(STROBE_SETUP_CYC)) begin
            link.write_strobe <= 1'b1;
          end
          if (cnt_r == 4'(STROBE_SETUP_CYC + STROBE_WIDTH_CYC)) begin
            link.write_strobe <= 1'b0;
            st_r <= ST_IDLE;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end
  // timing pins: clamps and sample strobes active low, line_start drives clamps
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      link.reset_n <= 1'b0;
      link.power_down_ctl <= 1'b0;
      link.preblank_ctl <= 1'b1;
      link.optical_black_pulse_n <= 1'b1;
      link.dummy_clamp_pulse_n <= 1'b1;
      link.reference_sample_strobe_n <= 1'b1;
      link.pixel_sample_strobe_n <= 1'b1;
      link.output_latch_clock <= 1'b0;
      latch_sync_r <= 3'h0;
      sample_word_out <= '0;
    end else begin
      link.reset_n <= !pins_r[PIN_RST];
      link.power_down_ctl <= pins_r[PIN_PD];
      link.preblank_ctl <= pins_r[PIN_PB];
      link.optical_black_pulse_n <= !line_start_in;
      link.dummy_clamp_pulse_n <= !line_start_in;
      link.reference_sample_strobe_n <= !ref_strobe_in;
      link.pixel_sample_strobe_n <= !pix_strobe_in;
      // foreign latch clock: three stages, follows once two and three agree
      latch_sync_r <= {latch_sync_r[1:0], latch_clock_in};
      if (latch_sync_r[1] == latch_sync_r[2]) begin
        link.output_latch_clock <= latch_sync_r[2];
      end
      sample_word_out <= link.out_word;
    end
  end
endmodule
`default_nettype wire

// File: hdl/cfp_device.sv
// front end device model: serial level registers and output latch
`timescale 1ns/1ps
`default_nettype none
module cfp_device (
  input  wire logic                         mclk_in,
  input  wire logic                         arst_n_in,
  cfp_link_if.device                        link,
  input  wire logic [cfp_pkg::OUT_W-1:0]    conv_result_in,
  output logic [cfp_pkg::LEVEL_W-1:0]       gain_level_out,
  output logic [cfp_pkg::LEVEL_W-1:0]       aux_analog_out,
  output logic                              black_clamp_out,
  output logic                              ref_sample_out,
  output logic                              data_sample_out,
  output logic                              dummy_clamp_out
);
  import cfp_pkg::*;
  // three stage samplers for every pin input
  localparam int NS = 11;
  // idle level of every pin, so no false edge follows reset
  localparam logic [NS-1:0] PIN_IDLE = 11'h23e;
  logic [NS-1:0] pin_raw;
  logic [NS-1:0] s1_r;
  logic [NS-1:0] s2_r;
  logic [NS-1:0] s3_r;
  logic [NS-1:0] stable_r;
  logic [NS-1:0] prev_r;
  assign pin_raw = {link.power_down_ctl, link.preblank_ctl,
                    link.serial_clock, link.serial_data_in, link.write_strobe, link.reset_n,
                    link.optical_black_pulse_n, link.reference_sample_strobe_n,
                    link.pixel_sample_strobe_n, link.dummy_clamp_pulse_n,
                    link.output_latch_clock};
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s1_r <= PIN_IDLE;
      s2_r <= PIN_IDLE;
      s3_r <= PIN_IDLE;
      stable_r <= PIN_IDLE;
      prev_r <= PIN_IDLE;
    end else begin
      s1_r <= pin_raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < NS; i++) begin
        if (s2_r[i] == s3_r[i]) stable_r[i] <= s3_r[i];
      end
      prev_r <= stable_r;
    end
  end
  logic sclk_rise;
  logic sd_lvl;
  logic wrt_rise;
  logic rst_lo;
  logic latch_rise;
  assign sclk_rise  = stable_r[8] && !prev_r[8];
  assign sd_lvl     = stable_r[7];
  assign wrt_rise   = stable_r[6] && !prev_r[6];
  assign rst_lo     = !stable_r[5];
  assign latch_rise = stable_r[0] && !prev_r[0];
  // data pin sampled at same delay as clock pin, setup covers skew
  logic [FRAME_BITS-1:0] shift_r;
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      shift_r <= '0;
    end else if (sclk_rise) begin
      shift_r <= {shift_r[FRAME_BITS-2:0], sd_lvl};
    end
  end
  // start bit is shift_r[11] and is ignored; bit 10 selects target
  logic [LEVEL_W-1:0] gain_r;
  logic [LEVEL_W-1:0] aux_r;
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      gain_r <= LEVEL_RST;
      aux_r  <= LEVEL_RST;
    end else if (rst_lo) begin
      gain_r <= LEVEL_RST;
      aux_r  <= LEVEL_RST;
    end else if (wrt_rise) begin
      if (shift_r[CMD_SEL]) begin
        aux_r <= shift_r[LEVEL_W-1:0];
      end else begin
        gain_r <= shift_r[LEVEL_W-1:0];
      end
    end
  end
  assign gain_level_out = gain_r;
  assign aux_analog_out = aux_r;
  // output latch with power down and preblank overrides
  logic [OUT_W-1:0] latch_r;
  logic pd_lvl;
  logic pb_lvl;
  assign pd_lvl = stable_r[10];
  assign pb_lvl = stable_r[9];
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      latch_r <= POWERDOWN_CODE;
    end else if (pd_lvl) begin
      latch_r <= POWERDOWN_CODE;
    end else if (latch_rise) begin
      latch_r <= pb_lvl ? conv_result_in : PREBLANK_CODE;
    end
  end
  assign link.out_word = latch_r;
  // active low clamp and sampling pins become active high controls
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      black_clamp_out <= 1'b0;
      ref_sample_out  <= 1'b0;
      data_sample_out <= 1'b0;
      dummy_clamp_out <= 1'b0;
    end else begin
      black_clamp_out <= !stable_r[4];
      ref_sample_out  <= !stable_r[3];
      data_sample_out <= !stable_r[2];
      dummy_clamp_out <= !stable_r[1];
    end
  end
endmodule
`default_nettype wire

// File: hdl/cfp_fifo.sv
// parameterised flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module cfp_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 16
) (
  input  wire logic             mclk_in,
  input  wire logic             arst_n_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  output logic [WIDTH-1:0]      out_data_out,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("fifo depth must be a power of two");
  end
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0]      wp_r;
  logic [AW:0]      rp_r;
  logic             full;
  logic             empty;
  assign full  = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
  assign empty = (wp_r == rp_r);
  assign in_ready_out  = !full;
  assign out_valid_out = !empty;
  assign out_data_out  = mem_r[rp_r[AW-1:0]];
  // write side
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wp_r <= '0;
    end else if (in_valid_in && !full) begin
      wp_r <= wp_r + 1'b1;
    end
  end
  always_ff @(posedge mclk_in) begin
    if (in_valid_in && !full) begin
      mem_r[wp_r[AW-1:0]] <= in_data_in;
    end
  end
  // read side
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rp_r <= '0;
    end else if (out_ready_in && !empty) begin
      rp_r <= rp_r + 1'b1;
    end
  end
endmodule
`default_nettype wire

// File: hdl/cfp_link_if.sv
// pin level link between controller and front end device
`timescale 1ns/1ps
`default_nettype none
interface cfp_link_if;
  logic       serial_clock;
  logic       serial_data_in;
  logic       write_strobe;
  logic       reset_n;
  logic       power_down_ctl;
  logic       preblank_ctl;
  logic       optical_black_pulse_n;
  logic       reference_sample_strobe_n;
  logic       pixel_sample_strobe_n;
  logic       dummy_clamp_pulse_n;
  logic       output_latch_clock;
  logic [9:0] out_word;  // index 9 is out_msb, index 0 is out_lsb
  modport device (
    input  serial_clock, serial_data_in, write_strobe, reset_n, power_down_ctl,
    input  preblank_ctl, optical_black_pulse_n, reference_sample_strobe_n,
    input  pixel_sample_strobe_n, dummy_clamp_pulse_n, output_latch_clock,
    output out_word
  );
  modport ctrl (
    output serial_clock, serial_data_in, write_strobe, reset_n, power_down_ctl,
    output preblank_ctl, optical_black_pulse_n, reference_sample_strobe_n,
    output pixel_sample_strobe_n, dummy_clamp_pulse_n, output_latch_clock,
    input  out_word
  );
endinterface
`default_nettype wire

// File: hdl/cfp_pkg.sv
// constants shared by both ends of the front end control port
package cfp_pkg;
  localparam int LEVEL_W      = 10;
  localparam int FRAME_BITS   = 12;
  localparam int OUT_W        = 10;
  localparam logic [9:0] LEVEL_RST    = 10'h000;
  localparam logic [9:0] PREBLANK_CODE = 10'h020;  // negative full scale plus 32
  localparam logic [9:0] POWERDOWN_CODE = 10'h000;
  localparam int SCLK_PERIOD_NS = 100;
  localparam int MCLK_PERIOD_NS = 10;
  localparam int SCLK_HALF_CYC  = (SCLK_PERIOD_NS / 2 + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int STROBE_SETUP_NS  = 100;
  localparam int STROBE_SETUP_CYC = (STROBE_SETUP_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int STROBE_WIDTH_NS  = 50;
  localparam int STROBE_WIDTH_CYC = (STROBE_WIDTH_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int FIFO_DEPTH = 16;
  // avalon register byte offsets
  localparam logic [3:0] REG_CMD    = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_PINS   = 4'h8;
  // pins register field positions
  localparam int PIN_PD = 0;
  localparam int PIN_PB = 1;
  localparam int PIN_RST = 2;  // high holds the level register reset pin low
  // command word fields
  localparam int CMD_SEL = 10;
endpackage

// File: tb/cfp_link_sva.sv
// concurrent checks on the link between controller and device
`timescale 1ns/1ps
`default_nettype none
module cfp_link_sva
  import cfp_pkg::*;
(
  input wire logic       mclk_in,
  input wire logic       arst_n_in,
  input wire logic       serial_clock,
  input wire logic       serial_data_in,
  input wire logic       write_strobe,
  input wire logic       power_down_ctl,
  input wire logic       preblank_ctl,
  input wire logic       optical_black_pulse_n,
  input wire logic       dummy_clamp_pulse_n,
  input wire logic       output_latch_clock,
  input wire logic [9:0] out_word
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);
  logic [4:0] rise_cnt_r;
  logic       clk_d_r;
  // counts serial clock rises since the last write strobe
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rise_cnt_r <= 5'h00;
      clk_d_r    <= 1'b0;
    end else begin
      clk_d_r <= serial_clock;
      if (write_strobe) rise_cnt_r <= 5'h00;
      else if (serial_clock && !clk_d_r) rise_cnt_r <= rise_cnt_r + 5'h01;
    end
  end
  a_strobe_quiet_shift: assert property ($rose(serial_clock) |-> !write_strobe)
    else $error("write strobe high during shifting");
  a_frame_twelve_bits: assert property ($rose(write_strobe) |-> rise_cnt_r == 5'd12)
    else $error("frame length is not twelve bits");
  a_strobe_pulse_width: assert property ($rose(write_strobe) |-> write_strobe[*5] ##1 !write_strobe)
    else $error("write strobe width wrong");
  a_bit_clock_high: assert property ($rose(serial_clock) |-> serial_clock[*5] ##1 !serial_clock)
    else $error("serial clock high phase wrong");
  a_data_stable_high: assert property (serial_clock |-> $stable(serial_data_in))
    else $error("serial data moved while clock high");
  a_start_bit_sent: assert property ($rose(serial_clock) && rise_cnt_r == 5'd0 |-> !serial_data_in)
    else $error("start bit not as chosen");
  a_clamps_together: assert property (optical_black_pulse_n == dummy_clamp_pulse_n)
    else $error("clamp pins differ");
  a_powerdown_zero: assert property (power_down_ctl[*4] ##1 ($rose(output_latch_clock) && power_down_ctl)
    ##1 power_down_ctl[*8] |-> out_word == POWERDOWN_CODE)
    else $error("output not zero in power down");
  a_preblank_code: assert property ((!preblank_ctl && !power_down_ctl)[*4] ##1
    $rose(output_latch_clock) ##1 (!preblank_ctl && !power_down_ctl)[*8] |-> out_word == PREBLANK_CODE)
    else $error("preblank code missing");
  cover property ($rose(write_strobe));
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// self-checking bench joining controller and device ends
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import cfp_pkg::*;
  logic mclk_in = 1'b0, arst_n_in = 1'b0, latch_clock_in = 1'b0;
  logic [3:0] avs_address_in = 4'h0;
  logic avs_read_in = 1'b0, avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, rd;
  logic avs_waitrequest_out, line_start_in = 1'b0, ref_strobe_in = 1'b0, pix_strobe_in = 1'b0;
  logic [9:0] sample_word_out, gain_level_out, aux_analog_out, conv_result_in = 10'h000;
  logic [9:0] exp_gain, exp_aux;
  logic black_clamp_out, ref_sample_out, data_sample_out, dummy_clamp_out;
  int mismatches = 0, checks_done = 0;
  cfp_link_if link ();
  // clocks: system at 100 MHz, latch clock unrelated at 125 ns
  always #5 mclk_in = ~mclk_in;
  always #62.5 latch_clock_in = ~latch_clock_in;
  cfp_ctrl i_cfp_ctrl (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .line_start_in(line_start_in), .ref_strobe_in(ref_strobe_in), .pix_strobe_in(pix_strobe_in),
    .latch_clock_in(latch_clock_in), .link(link), .sample_word_out(sample_word_out));
  cfp_device i_cfp_device (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .link(link),
    .conv_result_in(conv_result_in), .gain_level_out(gain_level_out),
    .aux_analog_out(aux_analog_out), .black_clamp_out(black_clamp_out),
    .ref_sample_out(ref_sample_out), .data_sample_out(data_sample_out),
    .dummy_clamp_out(dummy_clamp_out));
  cfp_link_sva i_cfp_link_sva (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
    .serial_clock(link.serial_clock), .serial_data_in(link.serial_data_in),
    .write_strobe(link.write_strobe), .power_down_ctl(link.power_down_ctl),
    .preblank_ctl(link.preblank_ctl), .optical_black_pulse_n(link.optical_black_pulse_n),
    .dummy_clamp_pulse_n(link.dummy_clamp_pulse_n),
    .output_latch_clock(link.output_latch_clock), .out_word(link.out_word));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one avalon transfer, held until waitrequest is sampled low
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    do begin
      @(posedge mclk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 3000);
    rd = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    if (n >= 3000) chk(32'h1, 32'h0);
  endtask
  // polls status until the frame writer is idle
  task automatic wait_idle();
    int n;
    n = 0;
    repeat (4) @(posedge mclk_in);
    do begin
      av(1'b0, REG_STATUS, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 2000);
    chk(rd, 32'h0);
  endtask
  task automatic frame(input logic sel, input logic [9:0] v);
    av(1'b1, REG_CMD, {21'h0, sel, v});
    if (sel) exp_aux = v;
    else exp_gain = v;
  endtask
  task automatic levels();
    chk(gain_level_out, exp_gain);
    chk(aux_analog_out, exp_aux);
  endtask
  task automatic pins_out(input logic [31:0] p, input logic [9:0] e);
    av(1'b1, REG_PINS, p);
    repeat (60) @(posedge mclk_in);
    chk(link.out_word, e);
    chk(sample_word_out, e);
  endtask
  initial begin
    repeat (20000) @(posedge mclk_in);
    mismatches++;
    give_verdict();
  end
  // main sequence
  initial begin
    logic [9:0] tbl [4];
    tbl = '{10'h2a5, 10'h15a, 10'h3ff, 10'h001};
    exp_gain = LEVEL_RST;
    exp_aux = LEVEL_RST;
    repeat (3) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    av(1'b0, REG_STATUS, 32'h0);
    chk(rd, 32'h0);
    av(1'b0, REG_PINS, 32'h0);
    chk(rd, 32'h2);
    levels();
    av(1'b1, 4'hc, 32'hffff_ffff);
    av(1'b0, 4'hc, 32'h0);
    chk(rd, 32'h0);
    av(1'b0, REG_PINS, 32'h0);
    chk(rd, 32'h2);
    for (int i = 0; i < 4; i++) begin
      frame(i[0], tbl[i]);
      wait_idle();
      repeat (10) @(posedge mclk_in);
      levels();
    end
    for (int i = 0; i < 17; i++) frame(1'b0, 10'(i + 1));
    av(1'b0, REG_STATUS, 32'h0);
    chk(rd, 32'h3);
    wait_idle();
    repeat (10) @(posedge mclk_in);
    levels();
    // level register reset through the reset pin, then a fresh aux write
    av(1'b1, REG_PINS, 32'h6);
    av(1'b0, REG_PINS, 32'h0);
    chk(rd, 32'h6);
    repeat (10) @(posedge mclk_in);
    av(1'b1, REG_PINS, 32'h2);
    exp_gain = LEVEL_RST;
    exp_aux = LEVEL_RST;
    repeat (10) @(posedge mclk_in);
    levels();
    frame(1'b1, 10'h2b4);
    wait_idle();
    repeat (10) @(posedge mclk_in);
    levels();
    conv_result_in <= 10'h3c3;
    pins_out(32'h2, 10'h3c3);
    pins_out(32'h3, POWERDOWN_CODE);
    pins_out(32'h0, PREBLANK_CODE);
    conv_result_in <= 10'h155;
    pins_out(32'h2, 10'h155);
    for (int i = 0; i < 8; i++) begin
      line_start_in <= i[0];
      ref_strobe_in <= i[1];
      pix_strobe_in <= i[2];
      repeat (12) @(posedge mclk_in);
      chk({black_clamp_out, dummy_clamp_out, link.optical_black_pulse_n}, {i[0], i[0], !i[0]});
      chk({ref_sample_out, link.reference_sample_strobe_n}, {i[1], !i[1]});
      chk({data_sample_out, link.pixel_sample_strobe_n}, {i[2], !i[2]});
    end
    @(posedge mclk_in);
    arst_n_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    exp_gain = LEVEL_RST;
    exp_aux = LEVEL_RST;
    levels();
    give_verdict();
  end
endmodule
`default_nettype wire
